// ### include/pio_map.svh
/*
 shared-pin parallel port: widths, implemented-bit mask and reset values.
 assumes inclusion by bare name from the package and the design.
*/
`ifndef PIO_MAP_SVH
`define PIO_MAP_SVH
`define PIO_WIDTH 16
`define PIO_IMPL_MASK 16'hffff
`define PIO_DIR_RST 16'hffff
`define PIO_LAT_RST 16'h0000
`endif

// ### include/pio_pkg.sv
/*
 types for the shared-pin port: pin bundle and peripheral bundle.
 assumes pio_map.svh is on the include path.
*/
`include "pio_map.svh"
package pio_pkg;
  typedef logic [`PIO_WIDTH-1:0] word_t;
  // pad drive: out_en_n low while the port or the peripheral drives the pin
  typedef struct packed {
    word_t out;
    word_t out_en_n;
  } pad_drive_t;
  // sharing peripheral: enabled and actively driving per bit
  typedef struct packed {
    word_t enable;
    word_t drive;
    word_t out;
  } periph_drive_t;
endpackage

// ### design/shared_pin_parallel_port.sv
/*
 one port slice of 16 shared pins with direction, latch and pin-state paths.
 assumes a software write strobe per register on ref_clk, pad inputs asynchronous.
*/
`timescale 1ns/1ps
`include "pio_map.svh"
module shared_pin_parallel_port (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic dir_wr,
  input wire logic lat_wr,
  input wire logic pin_wr,
  input wire pio_pkg::word_t wr_data,
  input wire pio_pkg::periph_drive_t periph,
  input wire pio_pkg::word_t pad_in,
  output pio_pkg::pad_drive_t pad,
  output pio_pkg::word_t pin_direction_reg,
  output pio_pkg::word_t output_latch_reg,
  output pio_pkg::word_t pin_state_reg,
  output pio_pkg::word_t periph_in
);
  // ***********************************
  // software registers
  // ***********************************
  pio_pkg::word_t dir_next;
  pio_pkg::word_t lat_next;
  pio_pkg::word_t sync1_reg;
  pio_pkg::word_t pin_next;
  // per-bit nets: each bit has its own continuous driver in the loop below
  wire pio_pkg::word_t own;
  wire pio_pkg::pad_drive_t pad_next;
  wire pio_pkg::word_t periph_in_next;
  localparam pio_pkg::word_t impl_mask = `PIO_IMPL_MASK;

  always_comb begin
    dir_next = pin_direction_reg;
    lat_next = output_latch_reg;
    if (dir_wr) begin
      dir_next = wr_data & `PIO_IMPL_MASK;
    end
    // latch writes and pin-state writes land in the same latch
    if (lat_wr || pin_wr) begin
      lat_next = wr_data & `PIO_IMPL_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_direction_reg <= `PIO_DIR_RST & `PIO_IMPL_MASK;
      output_latch_reg <= `PIO_LAT_RST;
    end else if (clk_en) begin
      pin_direction_reg <= dir_next;
      output_latch_reg <= lat_next;
    end
  end

  // ***********************************
  // pin read path
  // ***********************************
  // pin level read whoever owns the driver
  assign pin_next = sync1_reg & `PIO_IMPL_MASK;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 16'h0000;
      pin_state_reg <= 16'h0000;
    end else if (clk_en) begin
      sync1_reg <= pad_in;
      pin_state_reg <= pin_next;
    end
  end

  // ***********************************
  // output muxes
  // ***********************************
  // per bit: a data mux and an enable mux, peripheral or port
  genvar i;
  generate
    for (i = 0; i < `PIO_WIDTH; i++) begin : g_bit
      // input-only peripherals never assert drive, so the pin stays the port's
      assign own[i] = periph.enable[i] & periph.drive[i];
      // data mux
      assign pad_next.out[i] = own[i] ? periph.out[i] : output_latch_reg[i];
      // enable mux; an unimplemented bit is driven only while the peripheral owns it
      assign pad_next.out_en_n[i] = own[i] ? 1'b0
        : (pin_direction_reg[i] | ~impl_mask[i]);
      // a port-driven bit feeds the peripheral zero, not its own output
      // only the second sync stage is read, so a metastable first stage never leaks
      assign periph_in_next[i] = (!own[i] && !pin_direction_reg[i]) ? 1'b0
        : pin_state_reg[i];
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pad <= '{out: 16'h0000, out_en_n: 16'hffff};
      periph_in <= 16'h0000;
    end else if (clk_en) begin
      pad <= pad_next;
      periph_in <= periph_in_next;
    end
  end

  // ***********************************
  // checks
  // ***********************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_owner_drives: assert property (clk_en && periph.enable[0] && periph.drive[0]
    |=> !pad.out_en_n[0] && pad.out[0] == $past(periph.out[0]))
    else $error("peripheral did not take pin 0");
  a_port_drives: assert property (clk_en && !periph.drive[1] && !pin_direction_reg[1]
    |=> !pad.out_en_n[1] && pad.out[1] == $past(output_latch_reg[1]))
    else $error("port did not drive pin 1");
  a_input_tristate: assert property (clk_en && !periph.drive[2] && pin_direction_reg[2]
    |=> pad.out_en_n[2])
    else $error("input pin driven");
  a_pin_write_latch: assert property (clk_en && pin_wr && !lat_wr
    |=> output_latch_reg == $past(wr_data))
    else $error("pin-state write missed latch");
  a_latch_write: assert property (clk_en && lat_wr |=> output_latch_reg == $past(wr_data))
    else $error("latch write lost");
  a_sync_read: assert property (clk_en ##1 clk_en |=> pin_state_reg == $past(pad_in, 2))
    else $error("pin read not two stages");
  a_read_owned: assert property (clk_en ##1 clk_en && periph.drive[3] |=>
    pin_state_reg[3] == $past(pad_in[3], 2))
    else $error("owned pin unreadable");
  a_no_loop: assert property (clk_en && !periph.drive[4] && !pin_direction_reg[4]
    |=> !periph_in[4])
    else $error("port output looped into peripheral");
  a_dir_reset: assert property ($fell(rst) |-> pin_direction_reg == 16'hffff)
    else $error("pins not inputs after reset");


  // ***********************************
  // reset checks
  // ***********************************
  a_reset_pad: assert property ($fell(rst) |->
    pad.out_en_n == 16'hffff && output_latch_reg == 16'h0000)
    else $error("pads not released after reset");
  a_reset_read: assert property ($fell(rst) |->
    pin_state_reg == 16'h0000 && periph_in == 16'h0000)
    else $error("read path not cleared by reset");

  // ***********************************
  // freeze checks
  // ***********************************
  // clk_en low must hold every flop, pads included
  a_freeze_regs: assert property (!clk_en |=> $stable(pin_direction_reg)
    && $stable(output_latch_reg) && $stable(pin_state_reg))
    else $error("registers moved while frozen");
  a_freeze_pad: assert property (!clk_en |=> $stable(pad) && $stable(periph_in))
    else $error("pad moved while frozen");

  // ***********************************
  // register checks
  // ***********************************
  a_dir_write: assert property (clk_en && dir_wr |=>
    pin_direction_reg == $past(wr_data))
    else $error("direction write lost");
  a_dir_hold: assert property (clk_en && !dir_wr |=> $stable(pin_direction_reg))
    else $error("direction changed without write");
  a_latch_hold: assert property (clk_en && !lat_wr && !pin_wr |=>
    $stable(output_latch_reg))
    else $error("latch changed without write");
  a_both_writes: assert property (clk_en && lat_wr && pin_wr |=>
    output_latch_reg == $past(wr_data))
    else $error("joint latch write lost");
  a_unimpl_zero: assert property (((pin_direction_reg | output_latch_reg | pin_state_reg)
    & ~impl_mask) == 16'h0000)
    else $error("unimplemented bit reads nonzero");
  a_unimpl_off: assert property ((pad.out_en_n | impl_mask) == 16'hffff)
    else $error("unimplemented bit driven");

  // ***********************************
  // mux checks, all bits; peripheral read on bit 5 only
  // ***********************************
  a_owner_all: assert property (clk_en |=>
    (pad.out_en_n & $past(own)) == 16'h0000)
    else $error("owned pin not driven by peripheral");
  a_owner_data: assert property (clk_en |=>
    ((pad.out ^ $past(periph.out)) & $past(own)) == 16'h0000)
    else $error("peripheral data not on pad");
  a_port_data: assert property (clk_en |=>
    ((pad.out ^ $past(output_latch_reg)) & ~$past(own)) == 16'h0000)
    else $error("latch data not on pad");
  a_port_enable: assert property (clk_en |=>
    ((pad.out_en_n ^ $past(pin_direction_reg)) & ~$past(own)) == 16'h0000)
    else $error("port enable does not follow direction");
  a_loop_all: assert property (clk_en |=>
    (periph_in & ~$past(own) & ~$past(pin_direction_reg)) == 16'h0000)
    else $error("port output looped into a peripheral");
  a_periph_read: assert property (clk_en && own[5] |=>
    periph_in[5] == $past(pin_state_reg[5]))
    else $error("owned pin level not passed to peripheral");

  c_handover: cover property (periph.enable[0] && periph.drive[0] ##1 !periph.drive[0]);
  c_enabled_idle: cover property (clk_en && periph.enable[1] && !periph.drive[1]
    && !pin_direction_reg[1]);
  c_dir_out: cover property (clk_en && dir_wr && wr_data == 16'h0000);
  c_pin_wr: cover property (clk_en && pin_wr);
endmodule

// ### dv/pad_model.sv
/*
 pin model: resolves each pad from the port driver or an outside level.
 assumes the bench supplies the outside level on every bit.
*/
`timescale 1ns/1ps
module pad_model (
  input wire pio_pkg::pad_drive_t pad,
  input wire pio_pkg::word_t ext_level,
  output pio_pkg::word_t pad_in
);
  // released bits show the outside level, never the last driven value
  assign pad_in = (pad.out & ~pad.out_en_n) | (ext_level & pad.out_en_n);
endmodule

// ### dv/testbench.sv
/*
 random self-checking bench for the shared-pin port.
 assumes a 100 ns ref_clk and the pin model on the pads.
*/
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 0, rst = 1, clk_en = 1, dir_wr = 0, lat_wr = 0, pin_wr = 0;
  pio_pkg::word_t wr_data = '0, ext = '0, dir = 16'hffff, lat = '0;
  pio_pkg::word_t pad_in, dir_q, lat_q, pin_q, pin_in;
  pio_pkg::periph_drive_t periph = '0;
  pio_pkg::pad_drive_t pad;
  logic [95:0] exp_q[$];
  int err_total = 0, checked = 0;
  always #50 ref_clk = ~ref_clk;
  shared_pin_parallel_port dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .dir_wr(dir_wr), .lat_wr(lat_wr), .pin_wr(pin_wr), .wr_data(wr_data),
    .periph(periph), .pad_in(pad_in), .pad(pad), .pin_direction_reg(dir_q),
    .output_latch_reg(lat_q), .pin_state_reg(pin_q), .periph_in(pin_in));
  pad_model pm (.pad(pad), .ext_level(ext), .pad_in(pad_in));
  task automatic chk(input logic [95:0] got, input logic [95:0] want);
    checked++;
    if (got !== want) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, want);
    end
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // peripheral owns a bit only while enabled and driving
  function automatic logic [95:0] model();
    pio_pkg::word_t own, prt, pin;
    own = periph.enable & periph.drive;
    prt = ~dir & ~own;
    pin = (own & periph.out) | (prt & lat) | (~own & ~prt & ext);
    return {dir, lat, pin, ~(own | prt), pin & (own | prt), pin & ~prt};
  endfunction
  always @(negedge ref_clk) if (exp_q.size() > 0) begin
    chk({dir_q, lat_q, pin_q, pad.out_en_n, pad.out & ~pad.out_en_n, pin_in},
      exp_q.pop_front());
  end
  initial begin
    void'($urandom(32'h0666));
    repeat (20) @(negedge ref_clk);
    rst = 0;
    @(posedge ref_clk);
    exp_q.push_back(model());
    for (int i = 0; i < 80; i++) begin
      @(negedge ref_clk);
      clk_en = $urandom_range(0, 3) != 0;
      wr_data = $urandom;
      ext = $urandom;
      periph.enable = $urandom;
      periph.drive = $urandom;
      periph.out = $urandom;
      case ($urandom_range(0, 2))
        0: dir_wr = 1;
        1: lat_wr = 1;
        default: pin_wr = 1;
      endcase
      // a strobe with clk_en low must leave the registers alone
      if (clk_en && dir_wr) dir = wr_data;
      else if (clk_en) lat = wr_data;
      @(negedge ref_clk);
      {dir_wr, lat_wr, pin_wr} = '0;
      clk_en = 1;
      if (i == 40) begin
        rst = 1;
        dir = 16'hffff;
        lat = '0;
        repeat (2) @(negedge ref_clk);
        rst = 0;
      end
      repeat (5) @(posedge ref_clk);
      exp_q.push_back(model());
    end
    repeat (2) @(posedge ref_clk);
    end_sim();
  end
endmodule
